// >>> design/pts_sequencer.sv
// Table-driven positioning sequencer with its buffer memory port.
// Assumes the host and the motion core run on clk; the manual mode switch
// is a pin and is synchronised here.
//
// Contract
// - Table mode takes orders from the table
// - Word 30 bit 5 enables table mode
// - Table mode sticks until power removal
// - Exactly one hundred entries, zero to 99
// - Four 32-bit fields from register pairs
// - Entries every ten registers, fields 0/2/4/6
// - Table range dedicated, not retained
// - Host writes table, start runs it
// - Enable on: mode change keeps data
// - Enable off: mode change reinitialises
// - Decode motion, timer, check, home codes
// - Decode jog, compensation, addressing codes
// - Prefix 1: operate, then wait start
// - Prefix 2: operate, then program end
// - Two-speed jog takes next entry speed
// - Zero-speed high-speed move is skipped
`timescale 1ns/1ps
`default_nettype none

module pts_sequencer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [13:0] bfm_addr,
    input  wire logic        bfm_wr,
    input  wire logic [15:0] bfm_wdata,
    input  wire logic        bfm_rd,
    output logic      [15:0] bfm_rdata,
    input  wire logic        manual_mode,
    input  wire logic        start,
    input  wire logic        op_done,
    output logic             op_valid,
    output logic      [7:0]  op_code,
    output logic      [31:0] op_position,
    output logic      [31:0] op_speed,
    output logic      [31:0] op_speed2,
    output logic      [31:0] op_aux,
    output logic             prog_end,
    output logic             busy,
    output logic             waiting,
    output logic             seq_error,
    output logic             table_active,
    output logic      [6:0]  exec_entry
);

    pts_pkg::pts_state_t state_q;
    pts_pkg::pts_state_t state_d;

    logic [15:0] tbl_q [pts_pkg::TBL_WORDS];
    logic [15:0] param_q [pts_pkg::PARAM_WORDS];
    logic        enable_q;
    logic        active_q;
    logic        manual_s;
    logic        manual_q;
    logic [6:0]  idx_q;
    logic [6:0]  idx_d;
    logic        err_q;
    logic        err_d;
    logic [15:0] rdata_q;
    logic [7:0]  code_q;
    logic        wait_q;
    logic        end_q;
    logic        legal_q;
    logic [31:0] pos_q;
    logic [31:0] spd_q;
    logic [31:0] spd2_q;
    logic [31:0] aux_q;

    // ----------------------------------------------------------------
    // Buffer memory address decode
    // ----------------------------------------------------------------
    logic [13:0] tbl_rel;
    logic [13:0] tbl_ent;
    logic [13:0] tbl_off;
    logic        in_tbl;
    logic [9:0]  tbl_widx;
    logic        hit_tbl;
    logic        hit_param;
    logic        hit_ctrl;
    logic [13:0] par_rel;
    logic [3:0]  par_idx;

    // Entry number and word within entry from register number
    assign tbl_rel  = bfm_addr - pts_pkg::TBL_BASE;
    assign tbl_ent  = tbl_rel / pts_pkg::ENTRY_STRIDE;
    assign tbl_off  = tbl_rel % pts_pkg::ENTRY_STRIDE;
    assign in_tbl   = (bfm_addr >= pts_pkg::TBL_BASE) &&
                      (bfm_addr <= pts_pkg::TBL_TOP);
    assign hit_tbl  = in_tbl && (tbl_off[3:0] < pts_pkg::ENTRY_USED);
    assign tbl_widx = {tbl_ent[6:0], tbl_off[2:0]};
    assign par_rel  = bfm_addr - pts_pkg::PARAM_BASE;
    assign hit_param = (bfm_addr >= pts_pkg::PARAM_BASE) &&
                       (par_rel < 14'(pts_pkg::PARAM_WORDS));
    assign par_idx  = par_rel[3:0];
    assign hit_ctrl = bfm_addr == pts_pkg::CTRL_WORD;

    // ----------------------------------------------------------------
    // Mode changeover and table mode
    // ----------------------------------------------------------------
    logic to_auto;
    logic to_manual;
    logic tbl_clear;
    logic par_init;

    pts_sync2 u_manual_sync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  (manual_mode),
        .dout (manual_s)
    );

    // Edges of the synchronised mode switch
    assign to_auto   = manual_q && !manual_s;
    assign to_manual = !manual_q && manual_s;
    assign par_init  = to_auto && !enable_q;
    assign tbl_clear = to_manual && !enable_q;

    // Enable flag, sticky table mode, mode history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_q <= 1'b0;
            active_q <= 1'b0;
            manual_q <= 1'b0;
        end else if (ce) begin
            manual_q <= manual_s;
            if (bfm_wr && hit_ctrl) begin
                enable_q <= bfm_wdata[pts_pkg::ENABLE_BIT];
            end
            if (enable_q) begin
                active_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Table storage and parameter buffer
    // ----------------------------------------------------------------
    // Table words; cleared on reset, kept while enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < pts_pkg::TBL_WORDS; i++) begin
                tbl_q[i] <= pts_pkg::WORD_RESET;
            end
        end else if (ce) begin
            if (tbl_clear) begin
                for (int i = 0; i < pts_pkg::TBL_WORDS; i++) begin
                    tbl_q[i] <= pts_pkg::WORD_RESET;
                end
            end else if (bfm_wr && hit_tbl) begin
                tbl_q[tbl_widx] <= bfm_wdata;
            end
        end
    end

    // Parameter words; back to defaults on manual to auto while enable is off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < pts_pkg::PARAM_WORDS; i++) begin
                param_q[i] <= pts_pkg::PARAM_DEFAULT;
            end
        end else if (ce) begin
            if (par_init) begin
                for (int i = 0; i < pts_pkg::PARAM_WORDS; i++) begin
                    param_q[i] <= pts_pkg::PARAM_DEFAULT;
                end
            end else if (bfm_wr && hit_param) begin
                param_q[par_idx] <= bfm_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [15:0] ctrl_view;
    logic [15:0] rd_sel;

    // Control word reads back the enable and the sticky mode state
    assign ctrl_view = {active_q, 9'h000, enable_q, 5'h00};
    assign rd_sel    = hit_tbl   ? tbl_q[tbl_widx] :
                       hit_param ? param_q[par_idx] :
                       hit_ctrl  ? ctrl_view : pts_pkg::WORD_RESET;

    // Read data register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= pts_pkg::WORD_RESET;
        end else if (ce && bfm_rd) begin
            rdata_q <= rd_sel;
        end
    end

    // ----------------------------------------------------------------
    // Entry fetch
    // ----------------------------------------------------------------
    logic [9:0]  cur_base;
    logic [9:0]  nxt_base;
    logic [6:0]  nxt_idx;
    logic [31:0] f_code;
    logic [31:0] f_pos;
    logic [31:0] f_spd;
    logic [31:0] f_aux;
    logic [31:0] f_spd2;
    logic [7:0]  d_base;
    logic        d_wait;
    logic        d_end;
    logic        d_legal;

    // Field words of current and following entry, low word first
    assign nxt_idx  = (idx_q == pts_pkg::LAST_ENTRY) ? idx_q :
                      idx_q + 7'h01;
    assign cur_base = {idx_q, 3'b000};
    assign nxt_base = {nxt_idx, 3'b000};
    assign f_code = {tbl_q[cur_base + pts_pkg::FLD_CODE + pts_pkg::HI_WORD],
                     tbl_q[cur_base + pts_pkg::FLD_CODE]};
    assign f_pos  = {tbl_q[cur_base + pts_pkg::FLD_POS + pts_pkg::HI_WORD],
                     tbl_q[cur_base + pts_pkg::FLD_POS]};
    assign f_spd  = {tbl_q[cur_base + pts_pkg::FLD_SPD + pts_pkg::HI_WORD],
                     tbl_q[cur_base + pts_pkg::FLD_SPD]};
    assign f_aux  = {tbl_q[cur_base + pts_pkg::FLD_AUX + pts_pkg::HI_WORD],
                     tbl_q[cur_base + pts_pkg::FLD_AUX]};
    assign f_spd2 = {tbl_q[nxt_base + pts_pkg::FLD_SPD + pts_pkg::HI_WORD],
                     tbl_q[nxt_base + pts_pkg::FLD_SPD]};

    pts_code_decode u_decode (
        .code       (f_code),
        .base       (d_base),
        .wait_after (d_wait),
        .end_after  (d_end),
        .legal      (d_legal)
    );

    // Latch the decoded entry for the motion core
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_q  <= pts_pkg::OP_HIGH_SPEED;
            wait_q  <= 1'b0;
            end_q   <= 1'b0;
            legal_q <= 1'b0;
            pos_q   <= 32'h00000000;
            spd_q   <= 32'h00000000;
            spd2_q  <= 32'h00000000;
            aux_q   <= 32'h00000000;
        end else if (ce && state_q == pts_pkg::ST_FETCH) begin
            code_q  <= d_base;
            wait_q  <= d_wait;
            end_q   <= d_end;
            legal_q <= d_legal;
            pos_q   <= f_pos;
            spd_q   <= f_spd;
            spd2_q  <= f_spd2;
            aux_q   <= f_aux;
        end
    end

    // ----------------------------------------------------------------
    // Sequencing
    // ----------------------------------------------------------------
    logic       run_ok;
    logic       is_jog2;
    logic       skip;
    logic       bad;
    logic [7:0] step_sum;
    logic       past_end;
    logic [6:0] adv_idx;

    // Runs only in table mode and automatic mode
    assign run_ok   = active_q && !manual_s;
    assign is_jog2  = code_q == pts_pkg::OP_JOG_TWO;
    assign skip     = (code_q == pts_pkg::OP_HIGH_SPEED) &&
                      (spd_q == 32'h00000000);
    assign bad      = !legal_q ||
                      (is_jog2 && idx_q == pts_pkg::LAST_ENTRY);
    // Two-speed jog consumes two entries
    assign step_sum = {1'b0, idx_q} + (is_jog2 ? 8'h02 : 8'h01);
    assign past_end = step_sum > {1'b0, pts_pkg::LAST_ENTRY};
    assign adv_idx  = step_sum[6:0];

    // Next state and entry index
    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        err_d   = err_q;
        if (!run_ok) begin
            state_d = pts_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                pts_pkg::ST_IDLE: begin
                    if (start) begin
                        idx_d   = pts_pkg::FIRST_ENTRY;
                        err_d   = 1'b0;
                        state_d = pts_pkg::ST_FETCH;
                    end
                end
                pts_pkg::ST_FETCH: begin
                    state_d = pts_pkg::ST_ISSUE;
                end
                pts_pkg::ST_ISSUE: begin
                    if (bad) begin
                        err_d   = 1'b1;
                        state_d = pts_pkg::ST_IDLE;
                    end else if (skip) begin
                        idx_d   = adv_idx;
                        state_d = past_end ? pts_pkg::ST_IDLE :
                                  pts_pkg::ST_FETCH;
                    end else begin
                        state_d = pts_pkg::ST_BUSY;
                    end
                end
                pts_pkg::ST_BUSY: begin
                    if (op_done) begin
                        if (wait_q) begin
                            state_d = pts_pkg::ST_WAIT;
                        end else if (end_q || past_end) begin
                            state_d = pts_pkg::ST_IDLE;
                        end else begin
                            idx_d   = adv_idx;
                            state_d = pts_pkg::ST_FETCH;
                        end
                    end
                end
                pts_pkg::ST_WAIT: begin
                    if (start) begin
                        idx_d   = adv_idx;
                        state_d = past_end ? pts_pkg::ST_IDLE :
                                  pts_pkg::ST_FETCH;
                    end
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= pts_pkg::ST_IDLE;
            idx_q   <= pts_pkg::FIRST_ENTRY;
            err_q   <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            idx_q   <= idx_d;
            err_q   <= err_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Order strobe and end pulse are handshake terms
    assign op_valid = ce && run_ok && state_q == pts_pkg::ST_ISSUE &&
                      !bad && !skip;
    assign prog_end = ce && run_ok && state_q == pts_pkg::ST_BUSY &&
                      op_done && !wait_q && (end_q || past_end);
    assign op_code      = code_q;
    assign op_position  = pos_q;
    assign op_speed     = spd_q;
    assign op_speed2    = spd2_q;
    assign op_aux       = aux_q;
    assign bfm_rdata    = rdata_q;
    assign busy         = state_q != pts_pkg::ST_IDLE;
    assign waiting      = state_q == pts_pkg::ST_WAIT;
    assign seq_error    = err_q;
    assign table_active = active_q;
    assign exec_entry   = idx_q;

endmodule

`default_nettype wire

// >>> design/pts_pkg.sv
// Constants, register map and state type of the positioning table sequencer.
// Assumes word addresses on the buffer memory port equal data register
// numbers, and the control word sits at its own low address.
package pts_pkg;

    // ----------------------------------------------------------------
    // Buffer memory map
    // ----------------------------------------------------------------
    localparam logic [13:0] CTRL_WORD    = 14'h001e; // Control word 30
    localparam int          ENABLE_BIT   = 5;        // Table mode enable
    localparam logic [13:0] TBL_BASE     = 14'h03e8; // First table word
    localparam logic [13:0] TBL_TOP      = 14'h07cf; // Last table word
    localparam logic [13:0] ENTRY_STRIDE = 14'h000a; // Words per entry step
    localparam logic [3:0]  ENTRY_USED   = 4'h8;     // Stored words per entry
    localparam logic [13:0] PARAM_BASE   = 14'h23f0; // Parameter buffer
    localparam int          PARAM_WORDS  = 16;
    localparam logic [15:0] PARAM_DEFAULT = 16'h0000; // Power-on value
    localparam logic [15:0] WORD_RESET   = 16'h0000;

    // ----------------------------------------------------------------
    // Table shape and field positions
    // ----------------------------------------------------------------
    localparam int          ENTRIES    = 100;
    localparam int          TBL_WORDS  = 800;
    localparam logic [6:0]  FIRST_ENTRY = 7'h00;
    localparam logic [6:0]  LAST_ENTRY  = 7'h63;
    localparam logic [9:0]  FLD_CODE   = 10'h000;
    localparam logic [9:0]  FLD_POS    = 10'h002;
    localparam logic [9:0]  FLD_SPD    = 10'h004;
    localparam logic [9:0]  FLD_AUX    = 10'h006;
    localparam logic [9:0]  HI_WORD    = 10'h001;

    // ----------------------------------------------------------------
    // Operation codes and prefixes
    // ----------------------------------------------------------------
    localparam logic [31:0] PFX_STEP   = 32'h00000064; // 100
    localparam logic [31:0] PFX_WAIT_LO = 32'h00000064;
    localparam logic [31:0] PFX_END_LO = 32'h000000c8; // 200
    localparam logic [31:0] PFX_END_HI = 32'h0000012c; // 300
    localparam logic [7:0] OP_HIGH_SPEED = 8'h00;
    localparam logic [7:0] OP_MULTI      = 8'h01;
    localparam logic [7:0] OP_TIMER      = 8'h04;
    localparam logic [7:0] OP_SERVO_CHK  = 8'h09;
    localparam logic [7:0] OP_MECH_HOME  = 8'h1c;
    localparam logic [7:0] OP_SET_EHOME  = 8'h1d;
    localparam logic [7:0] OP_EHOME      = 8'h1e;
    localparam logic [7:0] OP_INT_STOP   = 8'h1f;
    localparam logic [7:0] OP_JOG_ONE    = 8'h47;
    localparam logic [7:0] OP_JOG_TWO    = 8'h48;
    localparam logic [7:0] OP_COMP       = 8'h49;
    localparam logic [7:0] OP_COMP_COMPENSATION_CANCEL  = 8'h4c;
    localparam logic [7:0] OP_ABS_ADDR   = 8'h5a;
    localparam logic [7:0] OP_INC_ADDR   = 8'h5b;
    localparam logic [7:0] OP_SET_PV     = 8'h5c;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_ISSUE,
        ST_BUSY,
        ST_WAIT
    } pts_state_t;

endpackage

// >>> design/pts_sync2.sv
// Two-stage synchroniser for a level from outside the clock domain.
// Assumes one clock, asynchronous active-high reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none

module pts_sync2 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic din,
    output logic      dout
);

    logic meta_q;
    logic sync_q;

    // ----------------------------------------------------------------
    // Synchroniser stages
    // ----------------------------------------------------------------
    // First stage is read by the second only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else if (ce) begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule

`default_nettype wire

// >>> design/pts_code_decode.sv
// Operation code decoder: splits the wait and end prefixes off a table
// code and checks the remaining two-digit code. Purely combinational.
`timescale 1ns/1ps
`default_nettype none

module pts_code_decode (
    input  wire logic [31:0] code,
    output logic      [7:0]  base,
    output logic             wait_after,
    output logic             end_after,
    output logic             legal
);

    logic [31:0] rem;
    logic        in_range;

    // ----------------------------------------------------------------
    // Prefix split
    // ----------------------------------------------------------------
    // Leading digit 1 waits, leading digit 2 ends
    assign wait_after = (code >= pts_pkg::PFX_WAIT_LO) &&
                        (code <  pts_pkg::PFX_END_LO);
    assign end_after  = (code >= pts_pkg::PFX_END_LO) &&
                        (code <  pts_pkg::PFX_END_HI);
    assign in_range   = code < pts_pkg::PFX_END_HI;
    assign rem        = end_after  ? code - pts_pkg::PFX_END_LO :
                        wait_after ? code - pts_pkg::PFX_STEP : code;
    assign base       = rem[7:0];

    // ----------------------------------------------------------------
    // Legal code check
    // ----------------------------------------------------------------
    // Codes known to the sequencer
    always_comb begin
        unique case (base)
            pts_pkg::OP_HIGH_SPEED, pts_pkg::OP_MULTI,
            pts_pkg::OP_TIMER, pts_pkg::OP_SERVO_CHK,
            pts_pkg::OP_MECH_HOME, pts_pkg::OP_SET_EHOME,
            pts_pkg::OP_EHOME, pts_pkg::OP_INT_STOP:
                legal = in_range;
            pts_pkg::OP_JOG_ONE, pts_pkg::OP_JOG_TWO,
            pts_pkg::OP_COMP, pts_pkg::OP_COMP_COMPENSATION_CANCEL,
            pts_pkg::OP_ABS_ADDR, pts_pkg::OP_INC_ADDR,
            pts_pkg::OP_SET_PV:
                legal = in_range;
            default:
                legal = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// >>> verification/pts_properties.sv
// Checker on the sequencer's ports, bound into every instance.
// Assumes ce is held high by the surroundings.
`timescale 1ns/1ps
`default_nettype none
module pts_properties (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       start,
    input wire logic       op_valid,
    input wire logic       prog_end,
    input wire logic       busy,
    input wire logic       waiting,
    input wire logic       seq_error,
    input wire logic       table_active,
    input wire logic [6:0] exec_entry
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Mode, start and sequencing
    // ------------------------------------------------------------
    chk_mode_sticks: assert property (
        table_active |=> table_active) else $error("table mode dropped");
    chk_start_refused: assert property (
        start && !table_active && !busy |=> !busy)
        else $error("start taken while inactive");
    chk_issue_pulse: assert property (
        op_valid |=> !op_valid) else $error("issue pulse too long");
    chk_entry_range: assert property (
        exec_entry <= 7'h63) else $error("entry index out of range");
    chk_wait_release: assert property (
        waiting && start |=> !waiting) else $error("wait not left");
    chk_end_idle: assert property (
        prog_end |=> !busy && !waiting) else $error("still busy after end");
    chk_first_entry: assert property (
        $rose(busy) |-> ##1 exec_entry == 7'h00)
        else $error("run not started at entry zero");
    chk_error_stops: assert property (
        $rose(seq_error) |-> ##[0:1] !busy) else $error("no stop on bad code");
endmodule
bind pts_sequencer pts_properties i_chk (.clk(clk), .rst(rst),
    .start(start), .op_valid(op_valid), .prog_end(prog_end), .busy(busy),
    .waiting(waiting), .seq_error(seq_error),
    .table_active(table_active), .exec_entry(exec_entry));
`default_nettype wire

// >>> verification/pts_motion_model.sv
// Motion core stand-in: answers each issued order after lat cycles.
// Assumes op_valid is a one-cycle pulse and lat is at least 2.
`timescale 1ns/1ps
`default_nettype none
module pts_motion_model (
    input  wire logic       clk,
    input  wire logic       op_valid,
    input  wire logic [3:0] lat,
    output logic            op_done
);
    logic       seen = 1'b0;
    logic [3:0] cnt = 4'h0;
    initial op_done = 1'b0;
    // Catch the order off the edge to avoid racing the issue pulse
    always @(negedge clk) seen <= op_valid;
    // Count down, then pulse completion for one cycle
    always @(posedge clk) begin
        op_done <= (cnt == 4'h1);
        if (seen)
            cnt <= lat;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
endmodule
`default_nettype wire

// >>> verification/tb_positioning_table_sequencer.sv
// Bench: host fills, runs and checks the table against a queue model.
// Assumes package, design, checker and motion model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_positioning_table_sequencer;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        man = 1'b0, start = 1'b0, done;
    logic        vld, pend, busy, waiting, err, active;
    logic [13:0] addr = 14'h0000;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [31:0] pos, spd, spd2, aux, lfsr = 32'h00000027;
    logic [7:0]  code;
    logic [6:0]  entry;
    logic [3:0]  lat = 4'h2;
    int          fails = 0, n_compared = 0, ends = 0;
    int unsigned q[$];
    pts_sequencer i_dut (.clk(clk), .rst(rst), .ce(1'b1), .bfm_addr(addr),
        .bfm_wr(wr), .bfm_wdata(wdata), .bfm_rd(rd), .bfm_rdata(rdata),
        .manual_mode(man), .start(start), .op_done(done), .op_valid(vld),
        .op_code(code), .op_position(pos), .op_speed(spd),
        .op_speed2(spd2), .op_aux(aux), .prog_end(pend), .busy(busy),
        .waiting(waiting), .seq_error(err), .table_active(active),
        .exec_entry(entry));
    pts_motion_model i_core (.clk(clk), .op_valid(vld), .lat(lat),
        .op_done(done));
    initial forever #12.5 clk = ~clk;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [13:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic put32(input logic [13:0] a, input logic [31:0] d);
        put(a, d[15:0]);
        put(a + 14'h0001, d[31:16]);
    endtask
    task automatic get(input logic [13:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic go();
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask
    task automatic await(input bit for_wait);
        for (int k = 0; k < 2000; k++) begin
            @(negedge clk);
            if (for_wait ? waiting === 1'b1 : busy === 1'b0) return;
        end
        fails++;
    endtask
    task automatic set_man(input logic m);
        @(posedge clk);
        man <= m;
        repeat (5) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Compare every issued order with the model queue
    always @(negedge clk) begin
        if (vld === 1'b1) begin
            cmp(code, q.pop_front());
            cmp(pos, q.pop_front());
            cmp(spd, q.pop_front());
            if (code === 8'h48) cmp(spd2, q.pop_front());
            else void'(q.pop_front());
            cmp(aux, q.pop_front());
        end
        if (pend === 1'b1) ends++;
    end
    initial begin
        #(25 * 20000);
        fails++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] r;
        static int   c[17] = '{0, 0, 1, 104, 9, 28, 29, 30, 31, 71, 72, 1,
                               73, 76, 90, 91, 292};
        int unsigned ps[18], sp[18];
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        go();
        repeat (4) @(negedge clk);
        cmp(busy, 0);
        put(14'h001e, 16'h0020);
        get(14'h001e, r);
        cmp(r, 16'h8020);
        for (int i = 0; i < 17; i++) begin
            lfsr = nxt(lfsr);
            ps[i] = lfsr;
            sp[i] = (i == 1) ? 0 : lfsr[15:0] + 1;
            put32(14'h03e8 + 14'(10 * i), c[i]);
            put32(14'h03ea + 14'(10 * i), ps[i]);
            put32(14'h03ec + 14'(10 * i), sp[i]);
            put32(14'h03ee + 14'(10 * i), ~ps[i]);
        end
        for (int i = 0; i < 17; i += (c[i] % 100 == 72) ? 2 : 1)
            if (c[i] % 100 != 0 || sp[i] != 0)
                q = {q, c[i] % 100, ps[i], sp[i], sp[i + 1], ~ps[i]};
        put(14'h23f0, 16'h00a5);
        set_man(1'b1);
        set_man(1'b0);
        get(14'h03ea, r);
        cmp(r, ps[0][15:0]);
        get(14'h23f0, r);
        cmp(r, 16'h00a5);
        go();
        await(1'b1);
        cmp(entry, 3);
        lat <= 4'h9;
        go();
        await(1'b0);
        cmp(ends, 1);
        cmp(q.size(), 0);
        $display("table run test done");
        put32(14'h03e8, 32'h00000037);
        go();
        await(1'b0);
        cmp(err, 1);
        get(14'h0100, r);
        cmp(r, 0);
        $display("bad code test done");
        put(14'h001e, 16'h0000);
        put(14'h23f0, 16'h1234);
        set_man(1'b1);
        get(14'h03ea, r);
        cmp(r, 0);
        go();
        repeat (3) @(negedge clk);
        cmp(busy, 0);
        set_man(1'b0);
        get(14'h23f0, r);
        cmp(r, 0);
        get(14'h001e, r);
        cmp(r, 16'h8000);
        cmp(active, 1);
        $display("mode change test done");
        print_verdict();
    end
endmodule
`default_nettype wire
